// file: design/slm_monitor.sv
// What this block does
// - request above trip loads limit delay counter
// - fault, power loss, coast stop mean modulation lost
// - reaction chosen from three configured choices
// - modoff mode starts modoff delay on loss
// - modoff mode, return: monitor below monitoring limit
// - monitoring starts at latest on limit delay expiry
// - midway speed starts monitoring and sets indication
// - monitor and disabled modes start zero-speed timer
// - monitor mode freezes last valid speed estimate
// - held speed above trip at expiry: emergency stop
// - after early return, above trip at expiry: stop
// - no return: indication only after zero-speed timer
// - disabled mode torques off on loss only during an emergency stop
// - modoff expiry without return: torque off, indicate
// - disabled mode return resumes ramp monitoring
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "slm_params.svh"

module slm_monitor #(
  parameter int SW = 16, // speed word width
  parameter int TW = 16  // delay counter width
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive status pins, asynchronous
  input wire logic modulation_on,
  input wire logic drive_fault,
  input wire logic power_loss,
  input wire logic coast_stop,
  // speed from drive control, same clock
  input wire logic [SW-1:0] motor_speed,
  // reactions and indications
  output logic limit_indication,
  output logic emergency_stop,
  output logic torque_off,
  output logic torque_off_indication,
  output logic ramp_monitor,
  output logic irq
);

  initial
  begin
    if (SW < 2 || SW > 32 || TW < 2 || TW > 32)
      $error("slm_monitor width out of range");
  end

  // midpoint of two speeds, widened so the sum cannot wrap
  function automatic logic [SW-1:0] midway(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [SW:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    midway = sum[SW:1];
  endfunction : midway

  // pin synchronisers: three stages, second and third must agree
  slm_pkg::slm_pins_t sync1; // first stage, read only by sync2
  slm_pkg::slm_pins_t sync2;
  slm_pkg::slm_pins_t sync3;
  slm_pkg::slm_pins_t pins; // filtered levels
  slm_pkg::slm_pins_t next_pins;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      next_pins[i] = (sync2[i] == sync3[i]) ? sync3[i] : pins[i];
  end

  // synchroniser registers; pins reset to modulation off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins <= '0;
    end
    else if (ce)
    begin
      sync1 <= {coast_stop, power_loss, drive_fault, modulation_on};
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= next_pins;
    end
  end

  // any of these counts as lost modulation
  logic mod_lost;
  assign mod_lost = !pins[0] || pins[1] || pins[2] || pins[3];

  // software registers
  logic req; // limited_speed_function request
  logic [1:0] modloss_reaction_select;
  logic [TW-1:0] limit_time_delay;
  logic [TW-1:0] modulation_off_delay_time;
  logic [TW-1:0] time_to_zero_speed;
  logic [SW-1:0] trip_limit;
  logic [SW-1:0] speed_limit;
  logic [`SLM_IRQ_WIDTH-1:0] irq_status;
  logic [`SLM_IRQ_WIDTH-1:0] irq_mask;
  logic [`SLM_IRQ_WIDTH-1:0] events;
  logic next_req;
  logic [1:0] next_sel;
  logic [TW-1:0] next_limit_delay;
  logic [TW-1:0] next_modoff_delay;
  logic [TW-1:0] next_zero_delay;
  logic [SW-1:0] next_trip;
  logic [SW-1:0] next_limit;
  logic [`SLM_IRQ_WIDTH-1:0] next_irq_status;
  logic [`SLM_IRQ_WIDTH-1:0] next_irq_mask;
  logic next_irq;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en; // write takes effect this edge
  logic rd_hit; // address maps to a register
  logic [31:0] rd_word;

  slm_pkg::slm_state_e state;
  slm_pkg::slm_state_e next_state;
  logic [SW-1:0] held_speed; // safe speed estimate

  // read mux and address decode
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `SLM_OFF_CTRL: rd_word = {29'h0, modloss_reaction_select, req};
      `SLM_OFF_LIMIT_DELAY: rd_word = 32'(limit_time_delay);
      `SLM_OFF_MODOFF_DELAY: rd_word = 32'(modulation_off_delay_time);
      `SLM_OFF_ZERO_DELAY: rd_word = 32'(time_to_zero_speed);
      `SLM_OFF_TRIP_LIMIT: rd_word = 32'(trip_limit);
      `SLM_OFF_SPEED_LIMIT: rd_word = 32'(speed_limit);
      `SLM_OFF_STATUS: rd_word = {24'h0, mod_lost, 3'(state), ramp_monitor,
                                  torque_off, emergency_stop, limit_indication};
      `SLM_OFF_IRQ_STATUS: rd_word = 32'(irq_status);
      `SLM_OFF_IRQ_MASK: rd_word = 32'(irq_mask);
      `SLM_OFF_HELD_SPEED: rd_word = 32'(held_speed);
      default: rd_hit = 1'b0; // unmapped: zero data and an error
    endcase
  end

  // pready is registered, so every access phase lasts two cycles
  assign wr_en = psel && penable && pready && pwrite;

  always_comb
  begin
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready)
    begin
      next_prdata = pwrite ? 32'h0000_0000 : rd_word;
      next_pslverr = !rd_hit;
    end
    next_req = req;
    next_sel = modloss_reaction_select;
    next_limit_delay = limit_time_delay;
    next_modoff_delay = modulation_off_delay_time;
    next_zero_delay = time_to_zero_speed;
    next_trip = trip_limit;
    next_limit = speed_limit;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (wr_en)
    begin
      unique case (paddr)
        `SLM_OFF_CTRL:
        begin
          next_req = pwdata[`SLM_CTRL_REQ_BIT];
          next_sel = pwdata[`SLM_CTRL_SEL_MSB:`SLM_CTRL_SEL_LSB];
        end
        `SLM_OFF_LIMIT_DELAY: next_limit_delay = pwdata[TW-1:0];
        `SLM_OFF_MODOFF_DELAY: next_modoff_delay = pwdata[TW-1:0];
        `SLM_OFF_ZERO_DELAY: next_zero_delay = pwdata[TW-1:0];
        `SLM_OFF_TRIP_LIMIT: next_trip = pwdata[SW-1:0];
        `SLM_OFF_SPEED_LIMIT: next_limit = pwdata[SW-1:0];
        `SLM_OFF_IRQ_STATUS: next_irq_status = irq_status & ~pwdata[`SLM_IRQ_WIDTH-1:0];
        `SLM_OFF_IRQ_MASK: next_irq_mask = pwdata[`SLM_IRQ_WIDTH-1:0];
        default: next_req = req; // read-only or unmapped: no effect
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // bus and register flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      {modloss_reaction_select, req} <= `SLM_RST_CTRL;
      limit_time_delay <= TW'(`SLM_RST_DELAY);
      modulation_off_delay_time <= TW'(`SLM_RST_DELAY);
      time_to_zero_speed <= TW'(`SLM_RST_DELAY);
      trip_limit <= SW'(`SLM_RST_TRIP);
      speed_limit <= SW'(`SLM_RST_LIMIT);
      irq_status <= '0;
      irq_mask <= `SLM_RST_MASK;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      req <= next_req;
      modloss_reaction_select <= next_sel;
      limit_time_delay <= next_limit_delay;
      modulation_off_delay_time <= next_modoff_delay;
      time_to_zero_speed <= next_zero_delay;
      trip_limit <= next_trip;
      speed_limit <= next_limit;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // mode decode; the unused code behaves as disabled, the safe side of no stop
  logic sel_modoff;
  logic sel_monitor;
  logic sel_disabled;
  assign sel_modoff = (modloss_reaction_select == `SLM_SEL_MODOFF_DELAY);
  assign sel_monitor = (modloss_reaction_select == `SLM_SEL_MONITOR_ACTIVE);
  assign sel_disabled = !sel_modoff && !sel_monitor;

  // sequence state and derived triggers
  logic req_q; // request one cycle back
  logic lost_q; // loss one cycle back
  logic req_rise;
  logic lost_rise;
  logic above_trip;
  logic at_midway;
  logic limit_load;
  logic modoff_load;
  logic zero_load;
  logic limit_done;
  logic modoff_done;
  logic zero_done;
  logic [SW-1:0] next_held;
  logic next_indication;
  logic next_estop;
  logic next_torque_off;
  logic next_ramp_monitor;

  assign req_rise = req && !req_q;
  assign lost_rise = mod_lost && !lost_q;
  assign above_trip = held_speed > trip_limit;
  assign at_midway = held_speed <= midway(speed_limit, trip_limit);

  // the limit counter runs only for a request that arrives above the trip limit
  assign limit_load = (state == slm_pkg::ST_IDLE) && req_rise && above_trip;
  assign modoff_load = (state == slm_pkg::ST_RAMP) && lost_rise && sel_modoff;
  // also run in modoff mode, since the indication there waits on it too
  assign zero_load = (state == slm_pkg::ST_RAMP) && lost_rise;

  slm_timer #(.TW(TW)) u_limit_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(limit_load),
    .clear(!req),
    .value(limit_time_delay),
    .running(),
    .done(limit_done)
  );

  slm_timer #(.TW(TW)) u_modoff_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(modoff_load),
    .clear(!req || !mod_lost),
    .value(modulation_off_delay_time),
    .running(),
    .done(modoff_done)
  );

  slm_timer #(.TW(TW)) u_zero_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(zero_load),
    .clear(!req || !mod_lost),
    .value(time_to_zero_speed),
    .running(),
    .done(zero_done)
  );

  // sequence decisions
  always_comb
  begin
    next_state = state;
    // estimate follows the drive except when frozen by a loss in monitoring mode
    next_held = (mod_lost && sel_monitor) ? held_speed : motor_speed;
    events = '0;
    unique case (state)
      slm_pkg::ST_IDLE:
      begin
        if (req_rise)
          next_state = above_trip ? slm_pkg::ST_RAMP : slm_pkg::ST_MONITOR;
      end
      slm_pkg::ST_RAMP:
      begin
        if (mod_lost)
        begin
          if (sel_modoff && modoff_done)
            next_state = slm_pkg::ST_TORQUE_OFF;
          else if (sel_monitor && limit_done && above_trip)
            next_state = slm_pkg::ST_ESTOP;
          else if (!sel_modoff && zero_done)
            next_state = slm_pkg::ST_MONITOR;
        end
        else if (limit_done && above_trip)
          next_state = slm_pkg::ST_ESTOP;
        else if (at_midway || limit_done)
          next_state = slm_pkg::ST_MONITOR;
      end
      slm_pkg::ST_MONITOR:
      begin
        // a trip limit hit on a live estimate stops the drive
        if (above_trip && !mod_lost)
          next_state = slm_pkg::ST_ESTOP;
      end
      slm_pkg::ST_ESTOP,
      slm_pkg::ST_TORQUE_OFF:
      begin
        next_state = state; // latched until the request is withdrawn
      end
    endcase
    if (!req)
      next_state = slm_pkg::ST_IDLE;
    next_indication = (next_state == slm_pkg::ST_MONITOR) ||
                      ((next_state == slm_pkg::ST_TORQUE_OFF) && zero_done);
    next_estop = (next_state == slm_pkg::ST_ESTOP);
    // torque-off comes from a modoff expiry or from the emergency stop on a coasting drive
    next_torque_off = (next_state == slm_pkg::ST_TORQUE_OFF) ||
                      (next_estop && mod_lost);
    // ramp supervision pauses while disabled mode waits on a loss
    next_ramp_monitor = (next_state == slm_pkg::ST_RAMP) &&
                        !(mod_lost && sel_disabled);
    events[`SLM_IRQ_MONITOR_BIT] = next_indication && !limit_indication;
    events[`SLM_IRQ_ESTOP_BIT] = next_estop && !emergency_stop;
    events[`SLM_IRQ_TORQUE_OFF_BIT] = next_torque_off && !torque_off;
    events[`SLM_IRQ_MODLOSS_BIT] = lost_rise && (state == slm_pkg::ST_RAMP);
  end

  // sequence flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= slm_pkg::ST_IDLE;
      req_q <= 1'b0;
      lost_q <= 1'b0;
      held_speed <= '0;
      limit_indication <= 1'b0;
      emergency_stop <= 1'b0;
      torque_off <= 1'b0;
      torque_off_indication <= 1'b0;
      ramp_monitor <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      req_q <= req;
      lost_q <= mod_lost;
      held_speed <= next_held;
      limit_indication <= next_indication;
      emergency_stop <= next_estop;
      torque_off <= next_torque_off;
      torque_off_indication <= next_torque_off;
      ramp_monitor <= next_ramp_monitor;
    end
  end

  a_limit_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state == slm_pkg::ST_IDLE && req && !req_q && above_trip
    |=> state == slm_pkg::ST_RAMP && !limit_done)
    else $error("request above trip did not enter ramp");

  a_loss_decode: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ((sync2 & sync3 & 4'b1110) != '0 || !(sync2[0] || sync3[0])) |=> mod_lost)
    else $error("fault, power loss or coast stop not taken as loss");

  a_modoff_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && modoff_load && modulation_off_delay_time > 1 |=> u_modoff_timer.running)
    else $error("modoff delay not started");

  a_return_mon: assert property (@(posedge pclk) disable iff (!presetn)
    ce && req && state == slm_pkg::ST_RAMP && !mod_lost && at_midway && !limit_done
    |=> state == slm_pkg::ST_MONITOR ##0 limit_indication)
    else $error("monitoring not started below monitoring limit");

  a_limit_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    ce && req && state == slm_pkg::ST_RAMP && !mod_lost && limit_done && !above_trip
    |=> state == slm_pkg::ST_MONITOR)
    else $error("monitoring not started at limit delay expiry");

  a_held_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mod_lost && sel_monitor |=> $stable(held_speed))
    else $error("speed estimate moved while frozen");

  a_estop_held: assert property (@(posedge pclk) disable iff (!presetn)
    ce && req && state == slm_pkg::ST_RAMP && limit_done && above_trip
    && (sel_monitor || !mod_lost) |=> emergency_stop)
    else $error("no emergency stop above trip at limit expiry");

  a_ind_wait: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state == slm_pkg::ST_RAMP && mod_lost && !sel_modoff && !zero_done
    |=> !limit_indication)
    else $error("indication before zero-speed timer expired");

  a_no_torque: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sel_disabled && !emergency_stop && !torque_off |=> !torque_off)
    else $error("torque off in disabled mode");

  a_modoff_trip: assert property (@(posedge pclk) disable iff (!presetn)
    ce && req && state == slm_pkg::ST_RAMP && mod_lost && sel_modoff && modoff_done
    |=> torque_off && torque_off_indication)
    else $error("no torque off at modoff expiry");

  a_ramp_resume: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state == slm_pkg::ST_RAMP && sel_disabled && mod_lost ##1
    ce && state == slm_pkg::ST_RAMP && !mod_lost && next_state == slm_pkg::ST_RAMP
    |=> ramp_monitor)
    else $error("ramp monitoring not resumed after return");

endmodule : slm_monitor

`default_nettype wire

// file: design/slm_params.svh
`ifndef SLM_PARAMS_SVH
`define SLM_PARAMS_SVH

// register byte offsets on the apb window
`define SLM_OFF_CTRL 12'h000
`define SLM_OFF_LIMIT_DELAY 12'h004
`define SLM_OFF_MODOFF_DELAY 12'h008
`define SLM_OFF_ZERO_DELAY 12'h00C
`define SLM_OFF_TRIP_LIMIT 12'h010
`define SLM_OFF_SPEED_LIMIT 12'h014
`define SLM_OFF_STATUS 12'h018
`define SLM_OFF_IRQ_STATUS 12'h01C
`define SLM_OFF_IRQ_MASK 12'h020
`define SLM_OFF_HELD_SPEED 12'h024

// control register fields
`define SLM_CTRL_REQ_BIT 0
`define SLM_CTRL_SEL_LSB 1
`define SLM_CTRL_SEL_MSB 2

// modloss_reaction_select codes
`define SLM_SEL_MODOFF_DELAY 2'h0
`define SLM_SEL_MONITOR_ACTIVE 2'h1
`define SLM_SEL_DISABLED 2'h2

// interrupt event bit positions
`define SLM_IRQ_MONITOR_BIT 0
`define SLM_IRQ_ESTOP_BIT 1
`define SLM_IRQ_TORQUE_OFF_BIT 2
`define SLM_IRQ_MODLOSS_BIT 3
`define SLM_IRQ_WIDTH 4

// reset values
`define SLM_RST_CTRL 3'h0
`define SLM_RST_DELAY 32'h0000_0100
`define SLM_RST_TRIP 32'h0000_0400
`define SLM_RST_LIMIT 32'h0000_0300
`define SLM_RST_MASK 4'h0

`endif

// file: design/slm_pkg.sv
package slm_pkg;

  // supervisor sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAMP,
    ST_MONITOR,
    ST_ESTOP,
    ST_TORQUE_OFF
  } slm_state_e;

  // filtered drive status pins, one bit each
  typedef logic [3:0] slm_pins_t;

endpackage : slm_pkg

// file: design/slm_timer.sv
`timescale 1ns/1ps
`default_nettype none

// down counter that flags expiry and keeps the flag until reloaded or cleared
module slm_timer #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic clear,
  input wire logic [TW-1:0] value,
  // state
  output logic running,
  output logic done
);

  logic [TW-1:0] count; // cycles left
  logic [TW-1:0] next_count;
  logic next_done;

  initial
  begin
    if (TW < 2 || TW > 32)
      $error("slm_timer width out of range");
  end

  // load wins over clear; a zero value expires on the next edge
  always_comb
  begin
    next_count = count;
    next_done = done;
    if (load)
    begin
      next_count = value;
      next_done = (value == '0);
    end
    else if (clear)
    begin
      next_count = '0;
      next_done = 1'b0;
    end
    else if (count != '0)
    begin
      next_count = count - TW'(1);
      next_done = (count == {{(TW-1){1'b0}}, 1'b1});
    end
  end

  // registers frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign running = (count != '0);

  a_timer_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !load && !clear && count == {{(TW-1){1'b0}}, 1'b1} |=> done)
    else $error("timer did not expire at terminal count");

endmodule : slm_timer

`default_nettype wire

// file: dv/slm_drive_model.sv
`timescale 1ns/1ps
`default_nettype none

// drive control unit: ramps down on request, coasts while not modulating
module slm_drive_model #(
  parameter int SW = 16,
  parameter int STEP = 8 // decel per cycle, kept small so ramps span tens of cycles
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic load,
  input wire logic decel,
  input wire logic [SW-1:0] start_speed,
  input wire logic [SW-1:0] target,
  input wire logic [1:0] cause, // 0 none, 1 fault, 2 power loss, 3 coast stop
  // status seen by the monitor
  output logic modulation_on,
  output logic drive_fault,
  output logic power_loss,
  output logic coast_stop,
  output logic [SW-1:0] motor_speed
);
  // any stop cause ends modulation; speed then only coasts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      modulation_on <= 1'b0;
      drive_fault <= 1'b0;
      power_loss <= 1'b0;
      coast_stop <= 1'b0;
      motor_speed <= '0;
    end
    else
    begin
      modulation_on <= (cause == 2'h0);
      drive_fault <= (cause == 2'h1);
      power_loss <= (cause == 2'h2);
      coast_stop <= (cause == 2'h3);
      if (load)
        motor_speed <= start_speed;
      else if (cause != 2'h0)
        motor_speed <= motor_speed - SW'(motor_speed != '0); // coasting is slower than ramp
      else if (decel && motor_speed > target)
        motor_speed <= (motor_speed - target > SW'(STEP)) ? motor_speed - SW'(STEP) : target;
    end
  end
endmodule : slm_drive_model

`default_nettype wire

// file: dv/slm_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "slm_params.svh"

module slm_monitor_tb;
  // clock, reset and apb master
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // drive model control and monitor outputs
  logic load = 1'b0;
  logic decel = 1'b0;
  logic [15:0] start_speed = 16'h0000;
  logic [15:0] target = 16'h0000;
  logic [1:0] cause = 2'h0;
  logic modulation_on, drive_fault, power_loss, coast_stop;
  logic [15:0] motor_speed;
  logic limit_indication, emergency_stop, torque_off, torque_off_indication, ramp_monitor, irq;
  // bookkeeping
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;
  logic [31:0] held;
  logic er;
  logic [11:0] roff [9] = '{`SLM_OFF_CTRL, `SLM_OFF_LIMIT_DELAY, `SLM_OFF_MODOFF_DELAY,
    `SLM_OFF_ZERO_DELAY, `SLM_OFF_TRIP_LIMIT, `SLM_OFF_SPEED_LIMIT, `SLM_OFF_IRQ_STATUS,
    `SLM_OFF_IRQ_MASK, 12'h040};
  logic [31:0] rexp [9] = '{32'h0000_0000, `SLM_RST_DELAY, `SLM_RST_DELAY, `SLM_RST_DELAY,
    `SLM_RST_TRIP, `SLM_RST_LIMIT, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  always #12.5 pclk = ~pclk;

  slm_monitor u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modulation_on(modulation_on),
    .drive_fault(drive_fault), .power_loss(power_loss), .coast_stop(coast_stop),
    .motor_speed(motor_speed), .limit_indication(limit_indication),
    .emergency_stop(emergency_stop), .torque_off(torque_off),
    .torque_off_indication(torque_off_indication), .ramp_monitor(ramp_monitor), .irq(irq));

  slm_drive_model u_drive (.pclk(pclk), .presetn(presetn), .load(load), .decel(decel),
    .start_speed(start_speed), .target(target), .cause(cause),
    .modulation_on(modulation_on), .drive_fault(drive_fault), .power_loss(power_loss),
    .coast_stop(coast_stop), .motor_speed(motor_speed));

  task conclude;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one transfer, then an idle cycle so no signal is assigned twice in one step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic pick(input int w);
    case (w)
      0: return limit_indication;
      1: return emergency_stop;
      2: return torque_off;
      default: return ramp_monitor;
    endcase
  endfunction : pick

  // bounded wait for a monitor output; n holds the cycles spent
  task wait_out(input int w, input int max);
    n = 0;
    while (pick(w) !== 1'b1 && n < max)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_out

  task window(input string name, input int lo, input int hi);
    check(name, 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : window

  // drop any old request, preload the drive, then raise a new request
  task start(input logic [1:0] sel, input logic [15:0] spd, input logic [15:0] tgt,
    input logic [31:0] lim);
    cause <= 2'h0;
    decel <= 1'b0;
    apb(1'b1, `SLM_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `SLM_OFF_LIMIT_DELAY, lim);
    load <= 1'b1;
    start_speed <= spd;
    target <= tgt;
    repeat (8) @(posedge pclk);
    load <= 1'b0;
    apb(1'b1, `SLM_OFF_CTRL, {29'h0000_0000, sel, 1'b1});
    decel <= 1'b1;
  endtask : start

  task lose(input logic [1:0] c, input int hold);
    cause <= c;
    if (hold > 0)
    begin
      repeat (hold) @(posedge pclk);
      cause <= 2'h0;
    end
  endtask : lose

  // hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, roff[i], 32'h0000_0000);
      check("reset value", rd, rexp[i]);
      check("slave error", 32'(er), 32'(i == 8));
    end
    apb(1'b1, `SLM_OFF_MODOFF_DELAY, 32'h0000_000A);
    apb(1'b1, `SLM_OFF_ZERO_DELAY, 32'h0000_001E);
    apb(1'b1, `SLM_OFF_IRQ_MASK, 32'h0000_000F);
    // modoff delay mode, modulation never returns
    start(`SLM_SEL_MODOFF_DELAY, 16'h0800, 16'h0300, 32'h0000_003C);
    apb(1'b0, `SLM_OFF_STATUS, 32'h0000_0000);
    check("state and ramp flag", 32'(rd[6:3]), 32'h0000_0003);
    lose(2'h1, 0);
    wait_out(2, 40);
    window("torque off delay", 10, 20);
    check("torque off indication", 32'(torque_off_indication), 32'h0000_0001);
    check("irq raised", 32'(irq), 32'h0000_0001);
    apb(1'b0, `SLM_OFF_IRQ_STATUS, 32'h0000_0000);
    check("loss and torque off events", rd, 32'h0000_000C);
    apb(1'b1, `SLM_OFF_IRQ_MASK, 32'h0000_0000);
    check("irq masked", 32'(irq), 32'h0000_0000);
    apb(1'b1, `SLM_OFF_IRQ_MASK, 32'h0000_000F);
    apb(1'b1, `SLM_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `SLM_OFF_IRQ_STATUS, 32'h0000_000F);
    @(posedge pclk);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    // modoff delay mode, modulation returns early, speed reaches midway
    start(`SLM_SEL_MODOFF_DELAY, 16'h0500, 16'h0300, 32'h0000_0190);
    lose(2'h2, 5);
    wait_out(2, 40);
    check("no torque off", 32'(torque_off), 32'h0000_0000);
    wait_out(0, 100);
    check("midway start", 32'(motor_speed <= 16'h0380 && motor_speed >= 16'h0340),
      32'h0000_0001);
    // speed parked above midway, spare select code: monitoring forced by limit delay
    start(2'h3, 16'h0500, 16'h03C0, 32'h0000_0028);
    wait_out(0, 80);
    window("limit delay start", 35, 45);
    check("no stop", 32'(emergency_stop), 32'h0000_0000);
    // monitoring active, no return: frozen estimate above trip
    apb(1'b1, `SLM_OFF_ZERO_DELAY, 32'h0000_0050);
    start(`SLM_SEL_MONITOR_ACTIVE, 16'h0800, 16'h0300, 32'h0000_0028);
    lose(2'h3, 0);
    repeat (8) @(posedge pclk);
    apb(1'b0, `SLM_OFF_HELD_SPEED, 32'h0000_0000);
    held = rd;
    repeat (6) @(posedge pclk);
    apb(1'b0, `SLM_OFF_HELD_SPEED, 32'h0000_0000);
    check("held speed", rd, held);
    wait_out(1, 60);
    check("stop on held speed", 32'(emergency_stop), 32'h0000_0001);
    check("torque off with stop", 32'(torque_off), 32'h0000_0001);
    // monitoring active, early return, drive parked above trip
    start(`SLM_SEL_MONITOR_ACTIVE, 16'h0800, 16'h0480, 32'h0000_0028);
    lose(2'h1, 5);
    wait_out(1, 60);
    check("stop after return", 32'(emergency_stop), 32'h0000_0001);
    // disabled mode, no return: indication waits for zero-speed timer
    apb(1'b1, `SLM_OFF_ZERO_DELAY, 32'h0000_001E);
    start(`SLM_SEL_DISABLED, 16'h0800, 16'h0300, 32'h0000_000A);
    lose(2'h2, 0);
    wait_out(0, 60);
    window("zero speed wait", 30, 40);
    check("no torque off", 32'(torque_off), 32'h0000_0000);
    check("no stop", 32'(emergency_stop), 32'h0000_0000);
    // disabled mode, return resumes ramp supervision
    start(`SLM_SEL_DISABLED, 16'h0800, 16'h0300, 32'h0000_0190);
    lose(2'h3, 5);
    repeat (3) @(posedge pclk);
    check("ramp paused", 32'(ramp_monitor), 32'h0000_0000);
    repeat (7) @(posedge pclk);
    check("ramp supervision", 32'(ramp_monitor), 32'h0000_0001);
    conclude();
  end
endmodule : slm_monitor_tb

`default_nettype wire
